// file: haes_event_select.sv
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
// Functional notes
// (RQ1) Code 0C counts directory lookups
// (RQ2) Lookup mask: bit0 snooped, bit1 unsnooped
// (RQ3) Directory events only with directory present
// (RQ4) Code 0D counts required directory updates
// (RQ5) Update mask: bit0 sets, bit1 clears
// (RQ6) Codes 59/5A add link2 credits per cycle
// (RQ7) Code 22 counts credit-starved cycles, four pools
// (RQ8) Code 17 adds up to four reads
// (RQ9) Bypass reads excluded from read count
// (RQ10) Code 1A counts writes, four classes
// (RQ11) Code 58 counts dropped zero-length writebacks
// (RQ12) Code 53 counts one per broadcasting request
// (RQ13) Code 54 counts early data returns
// (RQ14) Code 01 counts incoming requests
// (RQ15) Request mask bits 0-3 reads, writes
// (RQ16) Request mask bits 4-5 invalidate-to-exclusive
// (RQ17) Counters 0-3 only; one per cycle
// (RQ18) Several mask bits combine as OR
module haes_event_select
  import haes_pkg::*;
#(
  parameter int CTR_W     = 48,
  parameter int CRED_W    = 6,
  parameter bit DIR_PRESENT = 1'b1
) (
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire logic [3:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  // Event pulses from the home unit, all on ref_clk
  input  wire logic              dir_probe_snoop_required,
  input  wire logic              dir_probe_snoop_not_required,
  input  wire logic              dir_update_set,
  input  wire logic              dir_update_clear,
  input  wire logic [CRED_W-1:0] link2_addr_credit_sum,
  input  wire logic [CRED_W-1:0] link2_data_credit_sum,
  input  wire logic [3:0]        credit_starved_cycles,
  input  wire logic [3:0]        memctl_read_normal,
  input  wire logic [3:0]        memctl_read_bypass,
  input  wire logic [3:0]        memctl_write_tally,
  input  wire logic              zero_len_writeback_drop,
  input  wire logic [3:1]        opportunistic_broadcast,
  input  wire logic [4:1]        opportunistic_early_return,
  input  wire logic [5:0]        request_tally,
  output logic      [3:0]        ctr_active
);

  logic [31:0]      sel_q [HAES_NUM_CTR];
  logic [31:0]      sel_d [HAES_NUM_CTR];
  logic [CTR_W-1:0] cnt_q [HAES_NUM_CTR];
  logic [CTR_W-1:0] cnt_d [HAES_NUM_CTR];
  logic [CTR_W-1:0] inc   [HAES_NUM_CTR];
  logic [31:0]      rdata_d;
  logic [31:0]      rdata_q;
  logic [3:0]       act_d;
  logic [3:0]       act_q;

  // Set bits among four read lanes; the caller removes bypass reads first
  function automatic logic [HAES_RD_INC_W-1:0] popc4(input logic [3:0] v);
    popc4 = {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]};
  endfunction

  // Event mux for one counter; result is the increment this cycle
  function automatic logic [CTR_W-1:0] ev_inc(input logic [7:0] code, input logic [7:0] m);
    logic [CTR_W-1:0] r;
    r = '0;
    unique case (code)
      HAES_EV_DIR_PROBE:                                               // [RQ1]
        r[0] = DIR_PRESENT &&                                          // [RQ3]
               ((m[0] && dir_probe_snoop_required) ||                  // [RQ2]
                (m[1] && dir_probe_snoop_not_required));               // [RQ18]
      HAES_EV_DIR_UPDATE:                                              // [RQ4]
        r[0] = DIR_PRESENT &&                                          // [RQ3]
               ((m[0] && dir_update_set) || (m[1] && dir_update_clear)); // [RQ5]
      HAES_EV_L2_ADDR_CRED: r[CRED_W-1:0] = link2_addr_credit_sum;     // [RQ6]
      HAES_EV_L2_DATA_CRED: r[CRED_W-1:0] = link2_data_credit_sum;     // [RQ6]
      HAES_EV_CRED_STARVE:  r[0] = |(m[3:0] & credit_starved_cycles);   // [RQ7]
      HAES_EV_MEM_READ:                                                // [RQ8]
        if (m[0])
          r[HAES_RD_INC_W-1:0] = popc4(memctl_read_normal & ~memctl_read_bypass); // [RQ9]
      HAES_EV_MEM_WRITE:    r[0] = |(m[3:0] & memctl_write_tally);      // [RQ10]
      HAES_EV_ZLEN_WB_DROP: r[0] = zero_len_writeback_drop;            // [RQ11]
      HAES_EV_OPP_BCAST:    r[0] = |(m[3:1] & opportunistic_broadcast); // [RQ12]
      HAES_EV_OPP_EARLY:                                               // [RQ13]
        r[0] = (m[0] && |opportunistic_early_return) ||
               |(m[4:1] & opportunistic_early_return);
      HAES_EV_REQUESTS:     r[0] = |(m[5:0] & request_tally);          // [RQ14] [RQ15] [RQ16]
      default:              r = '0;
    endcase
    ev_inc = r;
  endfunction

  // Only four counters exist; other events never reach a wider bank
  for (genvar i = 0; i < HAES_NUM_CTR; i++) begin : g_ctr                // [RQ17]
    always_comb begin
      inc[i]   = ev_inc(sel_q[i][HAES_SEL_CODE_LSB +: 8], sel_q[i][HAES_SEL_MASK_LSB +: 8]);
      sel_d[i] = sel_q[i];
      cnt_d[i] = cnt_q[i] + inc[i];
      if (reg_wr && reg_addr == HAES_REG_SEL0 + 4'(i)) begin
        sel_d[i] = reg_wdata;
        sel_d[i][HAES_SEL_CLR_BIT] = 1'b0;
        // Clear restarts at zero, this cycle's event is dropped
        if (reg_wdata[HAES_SEL_CLR_BIT])
          cnt_d[i] = '0;
      end
      act_d[i] = |inc[i];
    end
    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        sel_q[i] <= HAES_SEL_RST;
        cnt_q[i] <= '0;
      end else begin
        sel_q[i] <= sel_d[i];
        cnt_q[i] <= cnt_d[i];
      end
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_rd) begin
      if (reg_addr <= HAES_REG_SEL3)
        rdata_d = sel_q[reg_addr[1:0]];
      else if (reg_addr <= HAES_REG_CNT3)
        rdata_d = 32'(cnt_q[reg_addr[1:0]]);
      else if (reg_addr == HAES_REG_STATUS)
        rdata_d = {28'h0, act_q};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_q <= 32'h0000_0000;
      act_q   <= 4'h0;
    end else begin
      rdata_q <= rdata_d;
      act_q   <= act_d;
    end
  end

  assign reg_rdata  = rdata_q;
  assign ctr_active = act_q;

  a_read_bound: assert property (@(posedge ref_clk) disable iff (sys_rst)
    sel_q[3][7:0] == HAES_EV_MEM_READ |-> inc[3] <= CTR_W'(HAES_MAX_RD_INC)) // [RQ8]
    else $error("read increment above four");
  a_single_inc: assert property (@(posedge ref_clk) disable iff (sys_rst)
    sel_q[0][7:0] == HAES_EV_REQUESTS |-> inc[0] <= CTR_W'(1)) // [RQ17]
    else $error("request increment above one");
  a_dir_lookup: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (sel_q[1][15:0] == 16'h030C && DIR_PRESENT &&
     (dir_probe_snoop_required || dir_probe_snoop_not_required) && !reg_wr)
    |=> cnt_q[1] == $past(cnt_q[1]) + CTR_W'(1)) // [RQ1]
    else $error("lookup not counted");
  a_no_bypass: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (sel_q[3][7:0] == HAES_EV_MEM_READ && (memctl_read_normal == memctl_read_bypass))
    |-> inc[3] == '0) // [RQ9]
    else $error("bypass read counted");
  a_act_follow: assert property (@(posedge ref_clk) disable iff (sys_rst)
    inc[3] != '0 |=> ctr_active[3]) // [RQ18]
    else $error("activity flag missed");
  a_clear_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
    reg_wr && reg_addr == HAES_REG_SEL0 && reg_wdata[HAES_SEL_CLR_BIT] |=> cnt_q[0] == '0) // [RQ17]
    else $error("clear failed");
  a_cred_add: assert property (@(posedge ref_clk) disable iff (sys_rst)
    sel_q[1][7:0] == HAES_EV_L2_ADDR_CRED |-> inc[1] == CTR_W'(link2_addr_credit_sum)) // [RQ6]
    else $error("credit sum wrong");
  a_wb_drop: assert property (@(posedge ref_clk) disable iff (sys_rst)
    sel_q[0][7:0] == HAES_EV_ZLEN_WB_DROP |-> inc[0][0] == zero_len_writeback_drop) // [RQ11]
    else $error("writeback drop wrong");

  // Per-counter checks, so these events are watched whichever counter holds them; codes 0C, 58 and 59 are checked above on one counter only
  for (genvar i = 0; i < HAES_NUM_CTR; i++) begin : g_chk
    a_upd_any: assert property (@(posedge ref_clk) disable iff (sys_rst)
      sel_q[i][15:0] == 16'h030D
      |-> inc[i] == CTR_W'(DIR_PRESENT && (dir_update_set || dir_update_clear))) // [RQ5]
      else $error("update count wrong");
    a_starve_pool: assert property (@(posedge ref_clk) disable iff (sys_rst)
      sel_q[i][7:0] == HAES_EV_CRED_STARVE
      |-> inc[i] == CTR_W'(|(sel_q[i][11:8] & credit_starved_cycles))) // [RQ7]
      else $error("starve count wrong");
    a_data_cred: assert property (@(posedge ref_clk) disable iff (sys_rst)
      sel_q[i][7:0] == HAES_EV_L2_DATA_CRED |-> inc[i] == CTR_W'(link2_data_credit_sum)) // [RQ6]
      else $error("data credit sum wrong");
    a_read_mask: assert property (@(posedge ref_clk) disable iff (sys_rst)
      sel_q[i][7:0] == HAES_EV_MEM_READ && !sel_q[i][8] |-> inc[i] == '0) // [RQ8]
      else $error("read counted without mask");
    a_write_one: assert property (@(posedge ref_clk) disable iff (sys_rst)
      sel_q[i][7:0] == HAES_EV_MEM_WRITE
      |-> inc[i] == CTR_W'(|(sel_q[i][11:8] & memctl_write_tally))) // [RQ10]
      else $error("write count wrong");
    a_bcast_one: assert property (@(posedge ref_clk) disable iff (sys_rst)
      sel_q[i][7:0] == HAES_EV_OPP_BCAST |-> inc[i] <= CTR_W'(1)) // [RQ12]
      else $error("broadcast above one");
    a_early_all: assert property (@(posedge ref_clk) disable iff (sys_rst)
      sel_q[i][7:0] == HAES_EV_OPP_EARLY && sel_q[i][8]
      |-> inc[i] == CTR_W'(|opportunistic_early_return)) // [RQ13]
      else $error("early return count wrong");
    a_req_inv: assert property (@(posedge ref_clk) disable iff (sys_rst)
      sel_q[i][7:0] == HAES_EV_REQUESTS && sel_q[i][11:8] == 4'h0
      |-> inc[i] == CTR_W'(|(sel_q[i][13:12] & request_tally[5:4]))) // [RQ16]
      else $error("inv-to-excl count wrong");
    a_req_rdwr: assert property (@(posedge ref_clk) disable iff (sys_rst)
      sel_q[i][7:0] == HAES_EV_REQUESTS && sel_q[i][13:12] == 2'h0
      |-> inc[i] == CTR_W'(|(sel_q[i][11:8] & request_tally[3:0]))) // [RQ15]
      else $error("read or write request count wrong");
    a_cnt_step: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !(reg_wr && reg_addr == HAES_REG_SEL0 + 4'(i) && reg_wdata[HAES_SEL_CLR_BIT])
      |=> cnt_q[i] == $past(cnt_q[i]) + $past(inc[i])) // [RQ17]
      else $error("counter step wrong");
  end

endmodule

// file: haes_pkg.sv
package haes_pkg;

  // Event codes
  localparam logic [7:0] HAES_EV_REQUESTS     = 8'h01;
  localparam logic [7:0] HAES_EV_DIR_PROBE    = 8'h0C;
  localparam logic [7:0] HAES_EV_DIR_UPDATE   = 8'h0D;
  localparam logic [7:0] HAES_EV_MEM_READ     = 8'h17;
  localparam logic [7:0] HAES_EV_MEM_WRITE    = 8'h1A;
  localparam logic [7:0] HAES_EV_CRED_STARVE  = 8'h22;
  localparam logic [7:0] HAES_EV_OPP_BCAST    = 8'h53;
  localparam logic [7:0] HAES_EV_OPP_EARLY    = 8'h54;
  localparam logic [7:0] HAES_EV_ZLEN_WB_DROP = 8'h58;
  localparam logic [7:0] HAES_EV_L2_ADDR_CRED = 8'h59;
  localparam logic [7:0] HAES_EV_L2_DATA_CRED = 8'h5A;

  // Register offsets (word index on the plain port)
  localparam logic [3:0] HAES_REG_SEL0   = 4'h0;
  localparam logic [3:0] HAES_REG_SEL1   = 4'h1;
  localparam logic [3:0] HAES_REG_SEL2   = 4'h2;
  localparam logic [3:0] HAES_REG_SEL3   = 4'h3;
  localparam logic [3:0] HAES_REG_CNT0   = 4'h4;
  localparam logic [3:0] HAES_REG_CNT3   = 4'h7;
  localparam logic [3:0] HAES_REG_STATUS = 4'h8;

  // Select register fields
  localparam int HAES_SEL_CODE_LSB = 0;
  localparam int HAES_SEL_MASK_LSB = 8;
  localparam int HAES_SEL_CLR_BIT  = 16;

  localparam int HAES_NUM_CTR      = 4;
  localparam int HAES_MAX_RD_INC   = 4;
  localparam int HAES_RD_INC_W     = 3;

  localparam logic [31:0] HAES_SEL_RST = 32'h0000_0000;

endpackage

// file: test_home_agent_event_select.sv
`timescale 1ns/1ps
module test_home_agent_event_select;
  import haes_pkg::*;
  logic        ref_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, zl = 0;
  logic [3:0]  reg_addr = 0, sr = 0, rn = 0, rb = 0, wt = 0, st, act;
  logic [31:0] reg_wdata = 0, reg_rdata;
  logic [5:0]  ac = 0, dc = 0, rq = 0;
  logic [3:1]  ob = 0;
  logic [4:1]  oe = 0;
  logic [1:0]  dp = 0, du = 0;
  logic [63:0] r;
  logic [7:0]  cd [4], mk [4];
  logic [7:0]  codes [12] = '{HAES_EV_REQUESTS, HAES_EV_DIR_PROBE, HAES_EV_DIR_UPDATE,
    HAES_EV_MEM_READ, HAES_EV_MEM_WRITE, HAES_EV_CRED_STARVE, HAES_EV_OPP_BCAST,
    HAES_EV_OPP_EARLY, HAES_EV_ZLEN_WB_DROP, HAES_EV_L2_ADDR_CRED,
    HAES_EV_L2_DATA_CRED, 8'h20};
  int          exp_c [4], v, n_fail = 0, check_count = 0, seed = 27;
  haes_event_select dut (
    .ref_clk                      (ref_clk),
    .sys_rst                      (sys_rst),
    .reg_addr                     (reg_addr),
    .reg_wdata                    (reg_wdata),
    .reg_wr                       (reg_wr),
    .reg_rd                       (reg_rd),
    .reg_rdata                    (reg_rdata),
    .dir_probe_snoop_required     (dp[0]),
    .dir_probe_snoop_not_required (dp[1]),
    .dir_update_set               (du[0]),
    .dir_update_clear             (du[1]),
    .link2_addr_credit_sum        (ac),
    .link2_data_credit_sum        (dc),
    .credit_starved_cycles        (sr),
    .memctl_read_normal           (rn),
    .memctl_read_bypass           (rb),
    .memctl_write_tally           (wt),
    .zero_len_writeback_drop      (zl),
    .opportunistic_broadcast      (ob),
    .opportunistic_early_return   (oe),
    .request_tally                (rq),
    .ctr_active                   (st)
  );
  initial forever #50 ref_clk = ~ref_clk;
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(e, reg_rdata);
    @(posedge ref_clk);
  endtask
  function automatic int inc(input logic [7:0] c, input logic [7:0] m);
    case (c)
      HAES_EV_DIR_PROBE:    return int'(|(m[1:0] & dp));
      HAES_EV_DIR_UPDATE:   return int'(|(m[1:0] & du));
      HAES_EV_L2_ADDR_CRED: return int'(ac);
      HAES_EV_L2_DATA_CRED: return int'(dc);
      HAES_EV_CRED_STARVE:  return int'(|(m[3:0] & sr));
      HAES_EV_MEM_READ:     return m[0] ? $countones(rn & ~rb) : 0;
      HAES_EV_MEM_WRITE:    return int'(|(m[3:0] & wt));
      HAES_EV_ZLEN_WB_DROP: return int'(zl);
      HAES_EV_OPP_BCAST:    return int'(|(m[3:1] & ob));
      HAES_EV_OPP_EARLY:    return int'(m[0] ? |oe : |(m[4:1] & oe));
      HAES_EV_REQUESTS:     return int'(|(m[5:0] & rq));
      default:              return 0;
    endcase
  endfunction
  task automatic end_sim;
    $display("Checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #1_000_000;
    n_fail++;
    end_sim;
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      for (int i = 0; i < 4; i++) begin
        cd[i] = codes[(k * 4 + i) % 12];
        mk[i] = (k == 0 && i == 1) ? 8'h03 : 8'($random(seed));
        exp_c[i] = 0;
        wr(4'(i), {15'h0, 1'b1, mk[i], cd[i]});
      end
      for (int t = 0; t < 200; t++) begin
        @(posedge ref_clk);
        for (int i = 0; i < 4; i++) begin
          v = inc(cd[i], mk[i]);
          exp_c[i] += v;
          act[i] = (v != 0);
        end
        r = {$random(seed), $random(seed)};
        if (t == 199) r = '0;
        {sr, rn, rb, wt, ob, oe, rq, dp, du, zl} <= r[33:0];
        ac <= r[39:34];
        dc <= r[45:40];
        #1 chk(32'(act), 32'(st));
      end
      @(posedge ref_clk);
      for (int i = 0; i < 4; i++) begin
        rd(HAES_REG_CNT0 + 4'(i), exp_c[i]);
        rd(4'(i), {16'h0, mk[i], cd[i]});
      end
      wr(4'hF, 32'($random(seed)));
      rd(4'hF, 32'h0000_0000);
      rd(HAES_REG_STATUS, 32'h0000_0000);
    end
    end_sim;
  end
endmodule
